// ==== src/hps_host_port.v ====
// Overview of operation
// - address/data multiplexing chosen by strap caught at reset release.
// - data path 16 or 32 bits by wide strap caught at reset release.
// - queue byte lane order big or little endian by strap at release.
// - D0 is least significant; D15 or D31 is most significant.
// - register data never byte swapped, whatever the endian strap.
// - registers are 16 bits and ride on D15..D0.
// - on a 32-bit path, D31..D16 are ignored for register writes.
// - queue data is a byte array kept in network arrival order.
// - big endian 16-bit: earlier byte on D15..D8, next on D7..D0.
// - big endian 32-bit: first byte on D31..D24, last on D7..D0.
// - little endian 16-bit: earlier byte on D7..D0, next on D15..D8.
// - little endian 32-bit: first byte on D7..D0, last on D31..D24.
`include "hps_defs.vh"
`default_nettype none
module hps_host_port #(
  parameter ADDR_W = 5
) (
  input wire mclk,
  input wire sys_rst,
  input wire bus_multiplex_select,
  input wire wide_bus_select,
  input wire little_endian_select,
  input wire [ADDR_W-1:0] host_addr,
  input wire host_ale,
  input wire host_cs_n,
  input wire host_rd_n,
  input wire host_wr_n,
  input wire [31:0] host_d_in,
  output reg [31:0] host_d_out,
  output wire host_d_oe_lo,
  output wire host_d_oe_hi,
  input wire rx_byte_valid,
  output wire rx_byte_ready,
  input wire [7:0] rx_byte,
  input wire rx_byte_last,
  output wire tx_byte_valid,
  input wire tx_byte_ready,
  output reg [7:0] tx_byte
);
  // ==========================================
  // lane mapping
  // bit offset of byte number idx within a queue word
  function [4:0] lane_off;
    input [1:0] idx;
    input wide;
    input le;
    begin
      if (le) begin
        lane_off = {idx, 3'h0};
      end else if (wide) begin
        lane_off = {2'h3 - idx, 3'h0};
      end else begin
        lane_off = {1'b0, ~idx[0], 3'h0};
      end
    end
  endfunction

  // ==========================================
  // strap capture
  reg rst_q_r;
  reg cfg_mux_r;
  reg cfg_wide_r;
  reg cfg_le_r;
  wire [2:0] nbytes;

  always @(posedge mclk) begin
    rst_q_r <= sys_rst;
    if (rst_q_r & ~sys_rst) begin
      cfg_mux_r <= bus_multiplex_select;
      cfg_wide_r <= wide_bus_select;
      cfg_le_r <= little_endian_select;
    end
  end
  assign nbytes = cfg_wide_r ? `HPS_BYTES_32 : `HPS_BYTES_16;

  // ==========================================
  // bus decode
  reg [ADDR_W-1:0] alat_r;
  reg rd_n_q_r;
  reg wr_n_q_r;
  wire [ADDR_W-1:0] addr;
  wire rd_take;
  wire wr_take;
  wire is_q;
  wire [3:0] ridx;

  always @(posedge mclk) begin
    if (sys_rst) begin
      alat_r <= {ADDR_W{1'b0}};
      rd_n_q_r <= 1'b1;
      wr_n_q_r <= 1'b1;
    end else begin
      if (host_ale) begin
        alat_r <= host_d_in[ADDR_W-1:0];
      end
      rd_n_q_r <= host_rd_n;
      wr_n_q_r <= host_wr_n;
    end
  end
  assign addr = cfg_mux_r ? alat_r : host_addr;
  assign rd_take = ~host_cs_n & ~host_rd_n & rd_n_q_r;
  assign wr_take = ~host_cs_n & ~host_wr_n & wr_n_q_r;
  assign is_q = addr[ADDR_W-1];
  assign ridx = addr[3:0];
  // upper lanes only on wide path
  assign host_d_oe_lo = ~host_cs_n & ~host_rd_n & ~host_ale;
  assign host_d_oe_hi = host_d_oe_lo & cfg_wide_r;

  // ==========================================
  // registers
  reg [15:0] ctrl_r;
  reg under_r;
  reg over_r;
  wire [15:0] status;
  wire [15:0] wlow;
  wire buf_valid;
  wire [31:0] buf_data;
  wire tx_busy;
  wire q_pop;

  assign wlow = host_d_in[`HPS_REG_W-1:0];
  assign status = {9'h000, tx_busy, over_r, under_r, buf_valid,
                   cfg_le_r, cfg_wide_r, cfg_mux_r};
  assign q_pop = rd_take & is_q & buf_valid;

  always @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_r <= `HPS_CTRL_RST;
      under_r <= 1'b0;
      over_r <= 1'b0;
    end else begin
      ctrl_r[`HPS_CT_FLUSH] <= 1'b0;
      if (wr_take & ~is_q & (ridx == `HPS_REG_CTRL)) begin
        ctrl_r <= wlow;
      end
      // sticky flags: set wins over write-one-to-clear
      if (rd_take & is_q & ~buf_valid) begin
        under_r <= 1'b1;
      end else if (wr_take & ~is_q & (ridx == `HPS_REG_STATUS) & wlow[`HPS_ST_UNDER]) begin
        under_r <= 1'b0;
      end
      if (wr_take & is_q & tx_busy) begin
        over_r <= 1'b1;
      end else if (wr_take & ~is_q & (ridx == `HPS_REG_STATUS) & wlow[`HPS_ST_OVER]) begin
        over_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // read data
  always @(posedge mclk) begin
    if (sys_rst) begin
      host_d_out <= 32'h00000000;
    end else if (rd_take) begin
      if (is_q) begin
        host_d_out <= buf_valid ? buf_data : 32'h00000000;
      end else if (ridx == `HPS_REG_ID) begin
        host_d_out <= {16'h0000, `HPS_ID_VALUE};
      end else if (ridx == `HPS_REG_STATUS) begin
        host_d_out <= {16'h0000, status};
      end else if (ridx == `HPS_REG_CTRL) begin
        host_d_out <= {16'h0000, ctrl_r};
      end else begin
        host_d_out <= 32'h00000000;
      end
    end
  end

  // ==========================================
  // receive packer
  reg [31:0] pk_word_r;
  reg [1:0] pk_cnt_r;
  reg pk_full_r;
  wire pk_ready;
  wire rx_take;
  wire [4:0] pk_off;
  wire pk_done;

  assign rx_byte_ready = ~pk_full_r & ctrl_r[`HPS_CT_RXEN];
  assign rx_take = rx_byte_valid & rx_byte_ready;
  assign pk_off = lane_off(pk_cnt_r, cfg_wide_r, cfg_le_r);
  assign pk_done = rx_byte_last | ({1'b0, pk_cnt_r} == nbytes - 3'h1);

  always @(posedge mclk) begin
    if (sys_rst | ctrl_r[`HPS_CT_FLUSH]) begin
      pk_word_r <= 32'h00000000;
      pk_cnt_r <= 2'h0;
      pk_full_r <= 1'b0;
    end else if (pk_full_r) begin
      if (pk_ready) begin
        pk_word_r <= 32'h00000000;
        pk_full_r <= 1'b0;
      end
    end else if (rx_take) begin
      pk_word_r <= pk_word_r | ({24'h000000, rx_byte} << pk_off);
      pk_cnt_r <= pk_done ? 2'h0 : pk_cnt_r + 2'h1;
      pk_full_r <= pk_done;
    end
  end

  hps_pair_buf #(
    .W(32)
  ) u_rx_buf (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .flush(ctrl_r[`HPS_CT_FLUSH]),
    .in_valid(pk_full_r),
    .in_ready(pk_ready),
    .in_data(pk_word_r),
    .out_valid(buf_valid),
    .out_ready(q_pop),
    .out_data(buf_data)
  );

  // ==========================================
  // transmit unpacker
  reg [31:0] tx_word_r;
  reg [1:0] tx_idx_r;
  reg [2:0] tx_left_r;
  wire [4:0] tx_off;
  wire [31:0] tx_sh;

  assign tx_busy = (tx_left_r != 3'h0);
  assign tx_byte_valid = tx_busy;
  assign tx_off = lane_off(tx_idx_r, cfg_wide_r, cfg_le_r);
  assign tx_sh = tx_word_r >> tx_off;

  always @(posedge mclk) begin
    if (sys_rst) begin
      tx_word_r <= 32'h00000000;
      tx_idx_r <= 2'h0;
      tx_left_r <= 3'h0;
    end else if (wr_take & is_q & ~tx_busy) begin
      // upper lanes unused on narrow path
      tx_word_r <= cfg_wide_r ? host_d_in : {16'h0000, host_d_in[15:0]};
      tx_idx_r <= 2'h0;
      tx_left_r <= nbytes;
    end else if (tx_busy & tx_byte_ready) begin
      tx_idx_r <= tx_idx_r + 2'h1;
      tx_left_r <= tx_left_r - 3'h1;
    end
  end

  always @* begin
    tx_byte = tx_sh[7:0];
  end
endmodule
`default_nettype wire

// ==== src/hps_defs.vh ====
`ifndef HPS_DEFS_VH
`define HPS_DEFS_VH
// register word indices (queue window when address msb is set)
`define HPS_REG_ID 4'h0
`define HPS_REG_STATUS 4'h1
`define HPS_REG_CTRL 4'h2
// identification value, arbitrary
`define HPS_ID_VALUE 16'hA5C3
// status fields
`define HPS_ST_MUX 0
`define HPS_ST_WIDE 1
`define HPS_ST_LE 2
`define HPS_ST_RXAVAIL 3
`define HPS_ST_UNDER 4
`define HPS_ST_OVER 5
`define HPS_ST_TXBUSY 6
// control fields
`define HPS_CT_FLUSH 0
`define HPS_CT_RXEN 1
`define HPS_CTRL_RST 16'h0002
// lane geometry
`define HPS_REG_W 16
`define HPS_BYTES_16 3'h2
`define HPS_BYTES_32 3'h4
`endif

// ==== src/hps_pair_buf.v ====
`default_nettype none
module hps_pair_buf #(
  parameter W = 32
) (
  input wire mclk,
  input wire sys_rst,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  // ==========================================
  // two-entry storage
  reg [W-1:0] mem0_r;
  reg [W-1:0] mem1_r;
  reg wr_ptr_r;
  reg rd_ptr_r;
  reg [1:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = rd_ptr_r ? mem1_r : mem0_r;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge mclk) begin
    if (sys_rst) begin
      mem0_r <= {W{1'b0}};
      mem1_r <= {W{1'b0}};
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else if (flush) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        if (wr_ptr_r) begin
          mem1_r <= in_data;
        end else begin
          mem0_r <= in_data;
        end
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/hps_host_port_assertions.sv ====
`include "hps_defs.vh"
`default_nettype none
module hps_host_port_assertions #(
  parameter ADDR_W = 5
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic bus_multiplex_select,
  input wire logic wide_bus_select,
  input wire logic little_endian_select,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic host_ale,
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic [31:0] host_d_out,
  input wire logic host_d_oe_lo,
  input wire logic host_d_oe_hi,
  input wire logic rx_byte_ready,
  input wire logic rx_byte_valid,
  input wire logic tx_byte_valid,
  input wire logic tx_byte_ready,
  input wire logic [7:0] tx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rst_q_r, rd_n_q_r, mux_r, wide_r, le_r;
  wire rd_take = !host_cs_n && !host_rd_n && rd_n_q_r && !mux_r && !host_addr[ADDR_W-1];
  // ==========
  // strap copy
  always @(posedge mclk) begin
    rst_q_r <= sys_rst;
    rd_n_q_r <= host_rd_n;
    if (rst_q_r && !sys_rst) begin
      {mux_r, wide_r, le_r} <= {bus_multiplex_select, wide_bus_select, little_endian_select};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ==========
  // checks
  property p_oe_lo; host_d_oe_lo == (!host_cs_n && !host_rd_n && !host_ale); endproperty
  a_oe_lo: assert property (p_oe_lo) else $error("low lane enable mismatch");
  property p_oe_hi; host_d_oe_hi |-> host_d_oe_lo; endproperty
  a_oe_hi: assert property (p_oe_hi) else $error("high lanes without low");
  property p_oe_wide; host_d_oe_lo |-> host_d_oe_hi == wide_r; endproperty
  a_oe_wide: assert property (p_oe_wide) else $error("lane enable width wrong");
  property p_reg_hi; rd_take |=> host_d_out[31:16] == 16'h0000; endproperty
  a_reg_hi: assert property (p_reg_hi) else $error("upper lanes not zero");
  property p_id; rd_take && host_addr[3:0] == `HPS_REG_ID |=> host_d_out[15:0] == `HPS_ID_VALUE;
  endproperty
  a_id: assert property (p_id) else $error("id value wrong");
  property p_status;
    rd_take && host_addr[3:0] == `HPS_REG_STATUS |=> host_d_out[2:0] == {le_r, wide_r, mux_r};
  endproperty
  a_status: assert property (p_status) else $error("strap status wrong");
  property p_tx_hold; tx_byte_valid && !tx_byte_ready |=> tx_byte_valid && $stable(tx_byte);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
  property p_rx_rel; $fell(sys_rst) |=> rx_byte_ready; endproperty
  a_rx_rel: assert property (p_rx_rel) else $error("rx not ready after reset");
  c_id: cover property (rd_take && host_addr[3:0] == `HPS_REG_ID);
  c_tx: cover property (tx_byte_valid && tx_byte_ready);
  c_stall: cover property (rx_byte_valid && !rx_byte_ready);
endmodule
`default_nettype wire

// ==== sim/hps_stream_model.sv ====
`default_nettype none
module hps_stream_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic rx_byte_ready,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_byte_last,
  input wire logic tx_byte_valid,
  output logic tx_byte_ready,
  input wire logic [7:0] tx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] next_r;
  logic [7:0] tx_q[$];
  assign rx_byte = rx_byte_valid ? next_r : ~next_r;
  assign rx_byte_last = 1'b0;
  always @(posedge mclk) begin
    if (sys_rst) begin
      rx_byte_valid <= 1'b0;
      next_r <= 8'h00;
      tx_byte_ready <= 1'b0;
      tx_q.delete();
    end else begin
      rx_byte_valid <= 1'b1;
      tx_byte_ready <= ~tx_byte_ready;
      if (rx_byte_valid && rx_byte_ready) next_r <= next_r + 8'h01;
      if (tx_byte_valid && tx_byte_ready) tx_q.push_back(tx_byte);
    end
  end
endmodule
`default_nettype wire

// ==== sim/test_hps_host_port.sv ====
`include "hps_defs.vh"
`default_nettype none
module test_hps_host_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, sys_rst, mux_s, wide_s, le_s, ale, cs_n, rd_n, wr_n, rxv, rxl, txr, txv, rxr;
  logic oe_lo, oe_hi;
  logic [4:0] addr;
  logic [7:0] rxb, txb;
  logic [31:0] drv, rdv, d_out, bus_w;
  int fails = 0;
  int comparisons = 0;
  assign bus_w = {oe_hi ? d_out[31:16] : drv[31:16], oe_lo ? d_out[15:0] : drv[15:0]};
  hps_host_port DUT (.mclk(mclk), .sys_rst(sys_rst), .bus_multiplex_select(mux_s),
    .wide_bus_select(wide_s), .little_endian_select(le_s), .host_addr(addr), .host_ale(ale),
    .host_cs_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_d_in(bus_w),
    .host_d_out(d_out), .host_d_oe_lo(oe_lo), .host_d_oe_hi(oe_hi), .rx_byte_valid(rxv),
    .rx_byte_ready(rxr), .rx_byte(rxb), .rx_byte_last(rxl), .tx_byte_valid(txv),
    .tx_byte_ready(txr), .tx_byte(txb));
  hps_stream_model model (.mclk(mclk), .sys_rst(sys_rst), .rx_byte_ready(rxr),
    .rx_byte_valid(rxv), .rx_byte(rxb), .rx_byte_last(rxl), .tx_byte_valid(txv),
    .tx_byte_ready(txr), .tx_byte(txb));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] lanes(input logic [31:0] w, input int n, input logic le);
    lanes = 32'h0;
    for (int i = 0; i < n; i++) lanes[(le ? i : n - 1 - i) * 8 +: 8] = w[i * 8 +: 8];
  endfunction
  task automatic acc(input logic [4:0] a, input logic wr, input logic [31:0] wd);
    @(posedge mclk) #1;
    if (mux_s) begin
      ale = 1'b1;
      drv = {27'h0, a};
      @(posedge mclk) #1;
      ale = 1'b0;
    end
    addr = a; drv = wd; cs_n = 1'b0; rd_n = wr; wr_n = ~wr;
    @(posedge mclk);
    @(posedge mclk) #1;
    rdv = d_out;
    cs_n = 1'b1; rd_n = 1'b1; wr_n = 1'b1;
  endtask
  task automatic run_cfg(input logic [2:0] cfg);
    int n;
    logic [31:0] tw;
    @(posedge mclk) #1;
    {le_s, wide_s, mux_s} = cfg;
    sys_rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (24) @(posedge mclk);
    n = wide_s ? 4 : 2;
    acc(5'h00, 1'b0, 32'h0); chk(rdv, {16'h0000, `HPS_ID_VALUE});
    acc(5'h01, 1'b0, 32'h0); chk(rdv, {28'h0, 1'b1, cfg});
    acc(5'h02, 1'b1, 32'hFFFF0002); acc(5'h02, 1'b0, 32'h0); chk(rdv, 32'h00000002);
    for (int k = 0; k < 2; k++) begin
      acc(5'h10, 1'b0, 32'h0);
      // word k holds network bytes k*n .. k*n+n-1
      tw = 32'h03020100 + 32'h01010101 * (k * n);
      chk(rdv, lanes(tw, n, le_s));
    end
    acc(5'h10, 1'b1, 32'hC4D3B2A1);
    // a second word while the wide unpacker is busy must be dropped
    if (wide_s) acc(5'h10, 1'b1, 32'h5A5A5A5A);
    repeat (16) @(posedge mclk);
    #1;
    chk(model.tx_q.size(), n);
    tw = lanes(32'hC4D3B2A1, n, le_s);
    for (int i = 0; i < n; i++) begin
      chk({24'h0, model.tx_q[i]}, {24'h0, tw[i * 8 +: 8]});
    end
    acc(5'h01, 1'b0, 32'h0); chk(rdv, {25'h0, 1'b0, wide_s, 1'b0, 1'b1, cfg});
    acc(5'h01, 1'b1, 32'h00000020); acc(5'h01, 1'b0, 32'h0);
    chk(rdv, {28'h0, 1'b1, cfg});
  endtask
  initial begin
    sys_rst = 1'b1; mux_s = 1'b0; wide_s = 1'b0; le_s = 1'b0; ale = 1'b0;
    cs_n = 1'b1; rd_n = 1'b1; wr_n = 1'b1; addr = 5'h00; drv = 32'h0;
    for (int c = 0; c < 8; c++) run_cfg(c[2:0]);
    finish_test;
  end
  initial begin
    #200000;
    fails++;
    finish_test;
  end
endmodule
bind hps_host_port hps_host_port_assertions #(.ADDR_W(ADDR_W)) u_chk (.mclk, .sys_rst,
  .bus_multiplex_select, .wide_bus_select, .little_endian_select, .host_addr, .host_ale,
  .host_cs_n, .host_rd_n, .host_d_out, .host_d_oe_lo, .host_d_oe_hi, .rx_byte_ready,
  .rx_byte_valid, .tx_byte_valid, .tx_byte_ready, .tx_byte);
`default_nettype wire
